//--- alu_core.sv
// alu datapath: divide, compare, logic, shift and bit operations
`timescale 1ns/10ps
module alu_core (
	input logic sys_clk,
	input logic nrst,
	input logic ce,
	input logic req_valid,
	output logic req_ready,
	input alu_pkg::op_type req_op,
	input alu_pkg::size_type req_size,
	input logic [alu_pkg::half_idx_w-1:0] req_dst,
	input logic [alu_pkg::half_idx_w-1:0] req_src,
	input logic req_use_imm,
	input logic [alu_pkg::data_w-1:0] req_imm,
	input logic req_bit_from_reg,
	input logic req_use_mem,
	input logic [alu_pkg::byte_w-1:0] req_mem_byte,
	output logic done,
	output logic mem_wr_valid,
	output logic [alu_pkg::byte_w-1:0] mem_wr_data,
	output alu_pkg::flags_type condition_flags,
	input logic flag_load,
	input alu_pkg::flags_type flag_load_value,
	input logic ext_wr_en,
	input logic [alu_pkg::reg_idx_w-1:0] ext_wr_idx,
	input logic [alu_pkg::data_w-1:0] ext_wr_data,
	input logic [alu_pkg::reg_idx_w-1:0] peek_idx,
	output logic [alu_pkg::data_w-1:0] peek_data
);
	import alu_pkg::*;
	typedef enum logic [1:0] {st_idle, st_read, st_exec, st_div} state_type;
	state_type state_r;
	op_type op_r;
	size_type size_r, dsz;
	logic [half_idx_w-1:0] dst_r, src_r;
	logic use_imm_r, bit_reg_r, use_mem_r, done_r, mem_wr_valid_r;
	logic [data_w-1:0] imm_r;
	logic [byte_w-1:0] mem_byte_r, mem_wr_data_r;
	flags_type flags_r, nf;
	logic [rd_ports-1:0][reg_idx_w-1:0] rd_addr;
	logic [rd_ports-1:0][data_w-1:0] rd_data;
	logic is_div, is_bit, is_cand, dsign, test_bit, div_zero, carry_now;
	logic ex, div_end, wb_en, wr_reg, wr_mem, set_nz, rf_we;
	logic [data_w-1:0] msk, d_op, s_reg, s_op, sub_a, sub_b, res, res_m;
	logic [data_w-1:0] msb_one, div_res, wb_data;
	logic [data_w:0] diff;
	logic [bitnum_w-1:0] bitn;
	logic [byte_w-1:0] bit_opnd, bit_res, sel;
	logic [3:0] rf_be;
	div_if dv();

	function automatic logic [data_w-1:0] size_mask(size_type s);
		unique case (s)
			size_byte: size_mask = byte_mask;
			size_word: size_mask = word_mask;
			default: size_mask = long_mask;
		endcase
	endfunction : size_mask

	function automatic logic msb_of(logic [data_w-1:0] x, size_type s);
		unique case (s)
			size_byte: msb_of = x[byte_msb];
			size_word: msb_of = x[word_msb];
			default: msb_of = x[long_msb];
		endcase
	endfunction : msb_of

	// half selector bit: byte 1 = low byte, word 1 = upper half
	function automatic logic [data_w-1:0] pick(logic [data_w-1:0] r,
		logic [half_idx_w-1:0] i, size_type s);
		unique case (s)
			size_byte: pick = {24'h0, i[half_sel] ? r[7:0] : r[15:8]};
			size_word: pick = {16'h0, i[half_sel] ? r[31:16] : r[15:0]};
			default: pick = r;
		endcase
	endfunction : pick

	function automatic logic [3:0] lanes(logic [half_idx_w-1:0] i, size_type s);
		unique case (s)
			size_byte: lanes = i[half_sel] ? be_b0 : be_b1;
			size_word: lanes = i[half_sel] ? be_hi : be_lo;
			default: lanes = be_all;
		endcase
	endfunction : lanes

	function automatic logic [data_w-1:0] place(logic [data_w-1:0] x, size_type s);
		unique case (s)
			size_byte: place = {4{x[7:0]}};
			size_word: place = {2{x[15:0]}};
			default: place = x;
		endcase
	endfunction : place

	assign ex = state_r == st_exec;
	assign div_end = state_r == st_div && dv.done;
	assign req_ready = state_r == st_idle;

	always_comb begin
		is_div = op_r inside {unsigned_divide, signed_divide};
		is_cand = op_r inside {carry_and_bit, carry_and_inverse_bit};
		is_bit = is_cand || (op_r inside {bit_set_op, bit_clear_op, bit_invert_op, bit_test_op});
		dsz = size_r;
		if (is_bit)
			dsz = size_byte;
		else if (is_div)
			dsz = (size_r == size_byte) ? size_word : size_long;
		msk = size_mask(dsz);
		d_op = pick(rd_data[port_dst], dst_r, dsz);
		s_reg = pick(rd_data[port_src], src_r, is_bit ? size_byte : size_r);
		s_op = use_imm_r ? (imm_r & size_mask(size_r)) : s_reg;
		dsign = msb_of(d_op, dsz);
		msb_one = ~(msk >> shift_step) & msk;
		// carry-and forms never take the bit number from a register
		bitn = (bit_reg_r && !is_cand) ? s_reg[bitnum_w-1:0] : imm_r[bitnum_w-1:0];
		bit_opnd = use_mem_r ? mem_byte_r : d_op[byte_w-1:0];
		test_bit = bit_opnd[bitn];
		sel = byte_w'(1) << bitn;
		sub_a = (op_r == negate_op) ? '0 : d_op;
		sub_b = (op_r == negate_op) ? d_op : s_op;
		diff = {1'h0, sub_a} - {1'h0, sub_b};
		div_zero = (s_op & size_mask(size_r)) == '0;
	end

	always_comb begin
		res = d_op;
		nf = flags_r;
		set_nz = 1'h0;
		wr_reg = 1'h0;
		wr_mem = 1'h0;
		bit_res = bit_opnd;
		unique case (op_r)
			compare_op, negate_op: begin
				res = diff[data_w-1:0];
				nf.c = diff[data_w];
				nf.v = (msb_of(sub_a, dsz) != msb_of(sub_b, dsz)) &&
					(msb_of(diff[data_w-1:0], dsz) != msb_of(sub_a, dsz));
				wr_reg = op_r == negate_op;
			end
			sign_extend_op: res = (dsz == size_long) ?
				{{half_w{d_op[word_msb]}}, d_op[15:0]} :
				{16'h0, {byte_w{d_op[byte_msb]}}, d_op[7:0]};
			zero_extend_op: res = (dsz == size_long) ?
				{16'h0, d_op[15:0]} : {24'h0, d_op[7:0]};
			and_op: res = d_op & s_op;
			or_op: res = d_op | s_op;
			xor_op: res = d_op ^ s_op;
			not_op: res = ~d_op;
			arith_shift_left, logic_shift_left: res = d_op << shift_step;
			arith_shift_right: res = (d_op >> shift_step) | (dsign ? msb_one : '0);
			logic_shift_right: res = d_op >> shift_step;
			rotate_left: res = (d_op << shift_step) | data_w'(dsign);
			rotate_right: res = (d_op >> shift_step) | (d_op[0] ? msb_one : '0);
			rotate_carry_left: res = (d_op << shift_step) | data_w'(flags_r.c);
			rotate_carry_right: res = (d_op >> shift_step) | (flags_r.c ? msb_one : '0);
			bit_set_op: bit_res = bit_opnd | sel;
			bit_clear_op: bit_res = bit_opnd & ~sel;
			bit_invert_op: bit_res = bit_opnd ^ sel;
			bit_test_op: nf.z = !test_bit;
			carry_and_bit: nf.c = flags_r.c & test_bit;
			carry_and_inverse_bit: nf.c = flags_r.c & !test_bit;
			default: nf.z = div_zero ? 1'h1 : flags_r.z;
		endcase
		if (op_r inside {compare_op, negate_op})
			set_nz = 1'h1;
		if (op_r inside {[sign_extend_op:rotate_carry_right]}) begin
			set_nz = 1'h1;
			wr_reg = 1'h1;
			nf.v = 1'h0;
		end
		if (op_r inside {[arith_shift_left:rotate_carry_right]}) begin
			// left forms lose the sign bit, right forms lose bit zero
			nf.c = (op_r inside {arith_shift_left, logic_shift_left, rotate_left, rotate_carry_left})
				? dsign : d_op[0];
			if (op_r == arith_shift_left)
				nf.v = dsign ^ msb_of(res, dsz);
		end
		if (op_r inside {bit_set_op, bit_clear_op, bit_invert_op}) begin
			wr_mem = use_mem_r;
			wr_reg = !use_mem_r;
			res = data_w'(bit_res);
		end
		res_m = res & msk;
		if (set_nz) begin
			nf.n = msb_of(res_m, dsz);
			nf.z = res_m == '0;
		end
	end

	// byte form: remainder in upper byte, quotient in lower byte
	assign div_res = (size_r == size_byte) ?
		{16'h0, dv.remainder[7:0], dv.quotient[7:0]} :
		{dv.remainder, dv.quotient};
	assign wb_en = (ex && wr_reg) || div_end;
	assign wb_data = place(div_end ? div_res : res_m, dsz);
	// the datapath wins a collision with an outside load
	assign rf_we = wb_en || ext_wr_en;
	assign rf_be = wb_en ? lanes(dst_r, dsz) : be_all;
	assign rd_addr[port_dst] = dst_r[reg_idx_w-1:0];
	assign rd_addr[port_src] = src_r[reg_idx_w-1:0];
	assign rd_addr[port_peek] = peek_idx;

	assign dv.start = ex && is_div && !div_zero;
	assign dv.is_word = size_r == size_word;
	assign dv.is_signed = op_r == signed_divide;
	assign dv.dividend = d_op;
	assign dv.divisor = s_op[half_w-1:0];

	reg_mem #(.width(data_w), .depth(reg_count), .aw(reg_idx_w), .nrd(rd_ports)) u_regs (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.ce(ce),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.wr_en(rf_we),
		.wr_addr(wb_en ? dst_r[reg_idx_w-1:0] : ext_wr_idx),
		.wr_data(wb_en ? wb_data : ext_wr_data),
		.wr_be(rf_be)
	);

	div_unit u_div (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.ce(ce),
		.dv(dv.unit)
	);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			state_r <= st_idle;
		else if (ce) begin
			unique case (state_r)
				st_idle: if (req_valid) state_r <= st_read;
				st_read: state_r <= st_exec;
				st_exec: state_r <= dv.start ? st_div : st_idle;
				st_div: if (dv.done) state_r <= st_idle;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			op_r <= compare_op;
			size_r <= size_byte;
			dst_r <= '0;
			src_r <= '0;
			use_imm_r <= 1'h0;
			imm_r <= '0;
			bit_reg_r <= 1'h0;
			use_mem_r <= 1'h0;
			mem_byte_r <= '0;
		end else if (ce && req_valid && req_ready) begin
			op_r <= req_op;
			size_r <= req_size;
			dst_r <= req_dst;
			src_r <= req_src;
			use_imm_r <= req_use_imm;
			imm_r <= req_imm;
			bit_reg_r <= req_bit_from_reg;
			use_mem_r <= req_use_mem;
			mem_byte_r <= req_mem_byte;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			flags_r <= flags_reset;
		else if (ce) begin
			if (ex)
				flags_r <= nf;
			else if (div_end) begin
				flags_r.n <= dv.is_word ? dv.quotient[word_msb] : dv.quotient[byte_msb];
				flags_r.z <= dv.is_word ? dv.quotient == '0 : dv.quotient[7:0] == '0;
			end else if (flag_load)
				flags_r <= flag_load_value;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			done_r <= 1'h0;
			mem_wr_valid_r <= 1'h0;
			mem_wr_data_r <= '0;
		end else if (ce) begin
			done_r <= (ex && !dv.start) || div_end;
			mem_wr_valid_r <= ex && wr_mem;
			if (ex && wr_mem)
				mem_wr_data_r <= bit_res;
		end
	end

	assign done = done_r;
	assign mem_wr_valid = mem_wr_valid_r;
	assign mem_wr_data = mem_wr_data_r;
	assign condition_flags = flags_r;
	assign peek_data = rd_data[port_peek];
	assign carry_now = flags_r.c;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst || !ce);
	property p_cmp;
		ex && op_r == compare_op |-> !wb_en ##1 condition_flags.z == ($past(res_m) == '0);
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare wrote or bad zero flag");
	property p_neg;
		ex && op_r == negate_op |-> wb_en && ((res_m + d_op) & msk) == '0;
	endproperty
	a_neg: assert property (p_neg) else $error("negate result wrong");
	property p_sext;
		ex && op_r == sign_extend_op && dsz == size_long |-> res_m[31:16] == {half_w{d_op[word_msb]}};
	endproperty
	a_sext: assert property (p_sext) else $error("sign extension wrong");
	property p_and;
		ex && op_r == and_op |-> wb_en && res_m == (d_op & s_op & msk);
	endproperty
	a_and: assert property (p_and) else $error("and result wrong");
	property p_not;
		ex && op_r == not_op |-> (res_m ^ d_op) == msk;
	endproperty
	a_not: assert property (p_not) else $error("complement wrong");
	property p_arith_shift_right;
		ex && op_r == arith_shift_right |-> msb_of(res_m, dsz) == dsign;
	endproperty
	a_arith_shift_right: assert property (p_arith_shift_right) else $error("arithmetic right lost sign");
	property p_rotc;
		ex && op_r == rotate_carry_left |-> res_m[0] == carry_now ##1 condition_flags.c == $past(dsign);
	endproperty
	a_rotc: assert property (p_rotc) else $error("carry rotate loop broken");
	property p_bit_set_op;
		ex && op_r == bit_set_op |-> bit_res[bitn] && (bit_res & ~sel) == (bit_opnd & ~sel);
	endproperty
	a_bit_set_op: assert property (p_bit_set_op) else $error("bit set wrong");
	property p_bit_invert_op;
		ex && op_r == bit_invert_op |-> (bit_res ^ bit_opnd) == sel;
	endproperty
	a_bit_invert_op: assert property (p_bit_invert_op) else $error("bit invert wrong");
	property p_bit_test_op;
		ex && op_r == bit_test_op |-> !wb_en ##1 condition_flags.z == !$past(test_bit);
	endproperty
	a_bit_test_op: assert property (p_bit_test_op) else $error("bit test zero flag wrong");
	property p_carry_and_inverse_bit;
		ex && op_r == carry_and_inverse_bit |=> condition_flags.c == ($past(carry_now) && !$past(test_bit));
	endproperty
	a_carry_and_inverse_bit: assert property (p_carry_and_inverse_bit) else $error("carry and inverse wrong");
	property p_lat;
		req_valid && req_ready |-> ##2 ex;
	endproperty
	a_lat: assert property (p_lat) else $error("operands not ready in two cycles");
	property p_shl;
		ex && op_r == logic_shift_left |-> res_m == ((d_op << shift_step) & msk);
	endproperty
	a_shl: assert property (p_shl) else $error("shift moved more than one bit");
	c_div: cover property (div_end);
	c_bmem: cover property (mem_wr_valid_r);
	c_rotc: cover property (ex && op_r == rotate_carry_right && carry_now);
endmodule : alu_core

//--- alu_pkg.sv
// shared constants and types of the alu datapath
package alu_pkg;
	localparam int data_w = 32;
	localparam int half_w = 16;
	localparam int byte_w = 8;
	localparam int reg_count = 8;
	localparam int reg_idx_w = 3;
	localparam int half_idx_w = 4;
	localparam int half_sel = 3;
	localparam int bitnum_w = 3;
	localparam int byte_msb = 7;
	localparam int word_msb = 15;
	localparam int long_msb = 31;
	localparam int shift_step = 1;
	localparam int rd_ports = 3;
	localparam int port_dst = 0;
	localparam int port_src = 1;
	localparam int port_peek = 2;
	localparam logic [31:0] byte_mask = 32'h0000_00ff;
	localparam logic [31:0] word_mask = 32'h0000_ffff;
	localparam logic [31:0] long_mask = 32'hffff_ffff;
	localparam logic [3:0] be_b0 = 4'h1;
	localparam logic [3:0] be_b1 = 4'h2;
	localparam logic [3:0] be_lo = 4'h3;
	localparam logic [3:0] be_hi = 4'hc;
	localparam logic [3:0] be_all = 4'hf;
	localparam int div_cnt_w = 6;
	localparam logic [5:0] div_steps_byte = 6'h10;
	localparam logic [5:0] div_steps_word = 6'h20;
	localparam logic [5:0] div_cnt_one = 6'h01;
	typedef enum logic [1:0] {size_byte, size_word, size_long} size_type;
	typedef enum logic [4:0] {
		unsigned_divide, signed_divide, compare_op, negate_op,
		sign_extend_op, zero_extend_op, and_op, or_op, xor_op, not_op,
		arith_shift_left, arith_shift_right, logic_shift_left, logic_shift_right,
		rotate_left, rotate_right, rotate_carry_left, rotate_carry_right,
		bit_set_op, bit_clear_op, bit_invert_op, bit_test_op,
		carry_and_bit, carry_and_inverse_bit
	} op_type;
	typedef struct packed {
		logic n;
		logic z;
		logic v;
		logic c;
	} flags_type;
	localparam flags_type flags_reset = 4'h0;
endpackage : alu_pkg

//--- div_if.sv
// handshake between the datapath and its iterative divider
`timescale 1ns/10ps
interface div_if;
	logic start;
	logic is_word;
	logic is_signed;
	logic [31:0] dividend;
	logic [15:0] divisor;
	logic done;
	logic [15:0] quotient;
	logic [15:0] remainder;
	modport ctrl (output start, is_word, is_signed, dividend, divisor,
		input done, quotient, remainder);
	modport unit (input start, is_word, is_signed, dividend, divisor,
		output done, quotient, remainder);
endinterface : div_if

//--- reg_mem.sv
// general register storage with byte lanes and registered read ports
`timescale 1ns/10ps
module reg_mem #(
	parameter int width = 32,
	parameter int depth = 8,
	parameter int aw = 3,
	parameter int nrd = 3
) (
	input logic sys_clk,
	input logic nrst,
	input logic ce,
	input logic [nrd-1:0][aw-1:0] rd_addr,
	output logic [nrd-1:0][width-1:0] rd_data,
	input logic wr_en,
	input logic [aw-1:0] wr_addr,
	input logic [width-1:0] wr_data,
	input logic [width/8-1:0] wr_be
);
	logic [width-1:0] mem [depth];
	// contents have no reset: software loads them before use
	always_ff @(posedge sys_clk) begin
		if (ce && wr_en) begin
			for (int b = 0; b < width / 8; b++) begin
				if (wr_be[b])
					mem[wr_addr][b*8 +: 8] <= wr_data[b*8 +: 8];
			end
		end
	end
	for (genvar p = 0; p < nrd; p++) begin : g_rd
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst)
				rd_data[p] <= '0;
			else if (ce)
				rd_data[p] <= mem[rd_addr[p]];
		end
	end
endmodule : reg_mem

//--- div_unit.sv
// restoring divider, one quotient bit per clock, signed or unsigned
`timescale 1ns/10ps
module div_unit (
	input logic sys_clk,
	input logic nrst,
	input logic ce,
	div_if.unit dv
);
	import alu_pkg::*;
	logic busy_r, done_r, neg_q_r, neg_r_r, signed_r;
	logic [div_cnt_w-1:0] cnt_r;
	logic [31:0] quo_r;
	logic [16:0] rem_r;
	logic [15:0] dsr_r, q_out_r, r_out_r;
	logic [16:0] rem_sh, rem_sub;
	logic fits, dvd_neg, dsr_neg;
	logic [31:0] dvd_mag, quo_nxt;
	logic [15:0] dsr_mag, rem_nxt;
	always_comb begin
		dvd_neg = dv.is_signed & (dv.is_word ? dv.dividend[long_msb] : dv.dividend[word_msb]);
		dsr_neg = dv.is_signed & (dv.is_word ? dv.divisor[word_msb] : dv.divisor[byte_msb]);
		if (dv.is_word) begin
			dvd_mag = dvd_neg ? 32'(-dv.dividend) : dv.dividend;
			dsr_mag = dsr_neg ? 16'(-dv.divisor) : dv.divisor;
		end else begin
			// byte form sits at the top so the same shift path serves both
			dvd_mag = {(dvd_neg ? 16'(-dv.dividend[15:0]) : dv.dividend[15:0]), 16'h0};
			dsr_mag = {8'h0, (dsr_neg ? 8'(-dv.divisor[7:0]) : dv.divisor[7:0])};
		end
	end
	assign rem_sh = {rem_r[15:0], quo_r[long_msb]};
	assign fits = rem_sh >= {1'h0, dsr_r};
	assign rem_sub = rem_sh - {1'h0, dsr_r};
	assign quo_nxt = {quo_r[30:0], fits};
	assign rem_nxt = fits ? rem_sub[15:0] : rem_sh[15:0];
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			busy_r <= 1'h0;
			done_r <= 1'h0;
			cnt_r <= '0;
			quo_r <= '0;
			rem_r <= '0;
			dsr_r <= '0;
			neg_q_r <= 1'h0;
			neg_r_r <= 1'h0;
			signed_r <= 1'h0;
			q_out_r <= '0;
			r_out_r <= '0;
		end else if (ce) begin
			done_r <= 1'h0;
			if (dv.start && !busy_r) begin
				busy_r <= 1'h1;
				cnt_r <= dv.is_word ? div_steps_word : div_steps_byte;
				quo_r <= dvd_mag;
				rem_r <= '0;
				dsr_r <= dsr_mag;
				neg_q_r <= dvd_neg ^ dsr_neg;
				neg_r_r <= dvd_neg;
				signed_r <= dv.is_signed;
			end else if (busy_r) begin
				quo_r <= quo_nxt;
				rem_r <= {1'h0, rem_nxt};
				cnt_r <= cnt_r - div_cnt_one;
				if (cnt_r == div_cnt_one) begin
					busy_r <= 1'h0;
					done_r <= 1'h1;
					q_out_r <= neg_q_r ? 16'(-quo_nxt[15:0]) : quo_nxt[15:0];
					r_out_r <= neg_r_r ? 16'(-rem_nxt) : rem_nxt;
				end
			end
		end
	end
	assign dv.done = done_r;
	assign dv.quotient = q_out_r;
	assign dv.remainder = r_out_r;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst || !ce);
	property p_div_len;
		dv.start && !busy_r |-> ##[17:33] done_r;
	endproperty
	a_div_len: assert property (p_div_len) else $error("divide did not finish");
	property p_div_rem;
		done_r && !signed_r |-> r_out_r < dsr_r;
	endproperty
	a_div_rem: assert property (p_div_rem) else $error("remainder not below divisor");
	property p_div_sign;
		done_r && signed_r && !neg_r_r |-> !r_out_r[word_msb];
	endproperty
	a_div_sign: assert property (p_div_sign) else $error("remainder sign wrong");
	c_div_signed: cover property (done_r && signed_r && neg_q_r);
endmodule : div_unit

//--- op_issuer.sv
// request side model: decoder handing operations to the datapath
`timescale 1ns/10ps
module op_issuer (
	input logic sys_clk,
	input logic req_ready,
	input logic done,
	output logic req_valid,
	output alu_pkg::op_type req_op,
	output alu_pkg::size_type req_size,
	output logic [3:0] req_dst,
	output logic [3:0] req_src,
	output logic req_use_imm,
	output logic [31:0] req_imm,
	output logic req_bit_from_reg,
	output logic req_use_mem,
	output logic [7:0] req_mem_byte
);
	import alu_pkg::*;
	initial begin
		req_valid = 1'b0;
		req_op = compare_op;
		req_size = size_byte;
		req_dst = 4'h0;
		req_src = 4'h0;
		req_use_imm = 1'b0;
		req_imm = 32'h0;
		req_bit_from_reg = 1'b0;
		req_use_mem = 1'b0;
		req_mem_byte = 8'h0;
	end
	// ok stays low if done never shows within the bound
	task automatic run(input op_type o, input size_type z, input logic [3:0] dd, ss,
		input logic u, input logic [31:0] v, input logic f, um, input logic [7:0] mv,
		output logic ok);
		int n;
		@(negedge sys_clk);
		req_op = o;
		req_size = z;
		req_dst = dd;
		req_src = ss;
		req_use_imm = u;
		req_imm = v;
		req_bit_from_reg = f;
		req_use_mem = um;
		req_mem_byte = mv;
		req_valid = 1'b1;
		while (!req_ready) @(negedge sys_clk);
		@(posedge sys_clk);
		@(negedge sys_clk);
		req_valid = 1'b0;
		// released immediate and memory byte toggle, nothing may lean on stale values
		req_imm = ~req_imm;
		req_mem_byte = ~req_mem_byte;
		ok = 1'b0;
		for (n = 0; n < 64 && !ok; n++) begin
			@(posedge sys_clk);
			#1;
			ok = (done === 1'b1);
		end
	endtask : run
endmodule : op_issuer

//--- cpu_alu_logic_shift_bit_ops_test.sv
// self-checking bench of the alu datapath
`timescale 1ns/10ps
module cpu_alu_logic_shift_bit_ops_test;
	import alu_pkg::*;
	logic sys_clk, nrst, ce, req_valid, req_ready, req_use_imm, req_bit_from_reg, req_use_mem;
	logic done, mem_wr_valid, flag_load, ext_wr_en, ok, c, ui, bfr, ov;
	op_type req_op, op;
	size_type req_size, sz;
	flags_type condition_flags, flag_load_value;
	logic [3:0] req_dst, req_src;
	logic [7:0] req_mem_byte, mem_wr_data, mb, m;
	logic [2:0] ext_wr_idx, peek_idx, d, s, k;
	logic [31:0] req_imm, ext_wr_data, peek_data, b, x, y;
	logic [32:0] e;
	logic [31:0] regs [8];
	int n_mismatch = 0, num_checks = 0, cyc = 0, i;
	op_type long_ops [16] = '{compare_op, negate_op, and_op, or_op, xor_op, not_op,
		arith_shift_left, arith_shift_right, logic_shift_left, logic_shift_right, rotate_left,
		rotate_right, rotate_carry_left, rotate_carry_right, sign_extend_op, zero_extend_op};
	op_type bit_ops [6] = '{bit_set_op, bit_clear_op, bit_invert_op, bit_test_op,
		carry_and_bit, carry_and_inverse_bit};
	logic [31:0] corner [4] = '{32'h0, 32'h1, 32'h8000_0000, 32'hffff_ffff};
	alu_core dut_u (.sys_clk, .nrst, .ce, .req_valid, .req_ready, .req_op, .req_size, .req_dst,
		.req_src, .req_use_imm, .req_imm, .req_bit_from_reg, .req_use_mem, .req_mem_byte, .done,
		.mem_wr_valid, .mem_wr_data, .condition_flags, .flag_load, .flag_load_value, .ext_wr_en,
		.ext_wr_idx, .ext_wr_data, .peek_idx, .peek_data);
	op_issuer drv_u (.sys_clk, .req_ready, .done, .req_valid, .req_op, .req_size, .req_dst,
		.req_src, .req_use_imm, .req_imm, .req_bit_from_reg, .req_use_mem, .req_mem_byte);
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// about 5000 cycles of traffic, hang bound well above
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			results();
		end
	end
	task automatic check(input string name, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results
	task automatic ld(input logic [2:0] a, input logic [31:0] v);
		@(negedge sys_clk);
		ext_wr_en = 1'b1;
		ext_wr_idx = a;
		ext_wr_data = v;
		regs[a] = v;
		@(negedge sys_clk);
		ext_wr_en = 1'b0;
	endtask : ld
	task automatic chk_reg(input logic [2:0] a);
		@(negedge sys_clk);
		peek_idx = a;
		@(posedge sys_clk);
		#1;
		check("reg", peek_data, regs[a]);
	endtask : chk_reg
	task automatic setc(input logic v);
		@(negedge sys_clk);
		flag_load = 1'b1;
		flag_load_value = {3'h0, v};
		@(negedge sys_clk);
		flag_load = 1'b0;
	endtask : setc
	task automatic issue(input op_type o, input size_type z, input logic [3:0] dd, ss,
		input logic u, input logic [31:0] v, input logic f, um, input logic [7:0] mv);
		drv_u.run(o, z, dd, ss, u, v, f, um, mv, ok);
		check("done", ok, 32'h1);
	endtask : issue
	function automatic logic [32:0] exp_long(input op_type o, input logic [31:0] a, v,
		input logic cf);
		case (o)
			compare_op: return {a < v, a};
			negate_op: return 33'h0 - {1'b0, a};
			and_op: return {cf, a & v};
			or_op: return {cf, a | v};
			xor_op: return {cf, a ^ v};
			not_op: return {cf, ~a};
			arith_shift_left, logic_shift_left: return {a, 1'b0};
			arith_shift_right: return {a[0], a[31], a[31:1]};
			logic_shift_right: return {a[0], 1'b0, a[31:1]};
			rotate_left: return {a, a[31]};
			rotate_right: return {a[0], a[0], a[31:1]};
			rotate_carry_left: return {a, cf};
			rotate_carry_right: return {a[0], cf, a[31:1]};
			sign_extend_op: return {cf, {16{a[15]}}, a[15:0]};
			default: return {cf, 16'h0, a[15:0]};
		endcase
	endfunction : exp_long
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		flag_load = 1'b0;
		flag_load_value = 4'h0;
		ext_wr_en = 1'b0;
		ext_wr_idx = 3'h0;
		ext_wr_data = 32'h0;
		peek_idx = 3'h0;
		void'($urandom(36));
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		nrst = 1'b1;
		check("flags", condition_flags, 32'h0);
		check("done", done, 32'h0);
		check("ready", req_ready, 32'h1);
		for (i = 0; i < 8; i++) ld(i[2:0], $urandom);
		for (i = 0; i < 320; i++) begin
			op = long_ops[i % 16];
			d = $urandom;
			s = $urandom;
			ui = $urandom;
			x = $urandom;
			c = $urandom;
			// last rounds push sign and zero boundaries
			if (i >= 256) ld(d, corner[(i / 16) % 4]);
			setc(c);
			b = ui ? x : regs[s];
			e = exp_long(op, regs[d], b, c);
			y = (op == compare_op) ? regs[d] - b : e[31:0];
			issue(op, size_long, {1'b0, d}, {1'b0, s}, ui, x, 1'b0, 1'b0, 8'h0);
			ov = (op == compare_op) ? (regs[d][31] != b[31] && y[31] != regs[d][31]) :
				(op == negate_op) ? (regs[d][31] && y[31]) :
				(op == arith_shift_left && regs[d][31] != regs[d][30]);
			check("neg", condition_flags.n, y[31]);
			check("ovf", condition_flags.v, ov);
			check("carry", condition_flags.c, e[32]);
			check("zero", condition_flags.z, y == 32'h0);
			regs[d] = e[31:0];
			chk_reg(d);
		end
		$display("test long operations done");
		for (i = 0; i < 96; i++) begin
			op = bit_ops[i / 16];
			mb = $urandom;
			c = $urandom;
			bfr = (i < 64) ? i[3] : 1'b0;
			ld(3'h5, $urandom);
			k = bfr ? regs[5][2:0] : i[2:0];
			m = 8'h1 << k;
			setc(c);
			issue(op, size_byte, 4'h8, 4'hd, 1'b1, 32'(i % 8), bfr, 1'b1, mb);
			check("memv", mem_wr_valid, op inside {bit_set_op, bit_clear_op, bit_invert_op});
			case (op)
				bit_set_op: check("mem", mem_wr_data, mb | m);
				bit_clear_op: check("mem", mem_wr_data, mb & ~m);
				bit_invert_op: check("mem", mem_wr_data, mb ^ m);
				bit_test_op: check("zero", condition_flags.z, !mb[k]);
				carry_and_bit: check("carry", condition_flags.c, c & mb[k]);
				default: check("carry", condition_flags.c, c & !mb[k]);
			endcase
		end
		$display("test bit operations done");
		// byte and word forms, upper half and high byte selection
		ld(3'h2, 32'h1234_80f0);
		issue(rotate_left, size_byte, 4'h2, 4'h0, 1'b0, 32'h0, 1'b0, 1'b0, 8'h0);
		check("carry", condition_flags.c, 32'h1);
		regs[2] = 32'h1234_01f0;
		chk_reg(3'h2);
		issue(sign_extend_op, size_word, 4'h2, 4'h0, 1'b0, 32'h0, 1'b0, 1'b0, 8'h0);
		check("neg", condition_flags.n, 32'h1);
		issue(xor_op, size_word, 4'ha, 4'h0, 1'b1, 32'hffff_1234, 1'b0, 1'b0, 8'h0);
		check("zero", condition_flags.z, 32'h1);
		issue(bit_clear_op, size_byte, 4'h2, 4'h0, 1'b1, 32'h7, 1'b0, 1'b0, 8'h0);
		check("memv", mem_wr_valid, 32'h0);
		regs[2] = 32'h0000_7ff0;
		chk_reg(3'h2);
		$display("test sized operations done");
		for (i = 0; i < 60; i++) begin
			op = (i % 3 == 2) ? signed_divide : unsigned_divide;
			sz = (i % 3 == 0) ? size_byte : size_word;
			d = $urandom;
			s = d + 3'h1;
			x = $urandom % 200 + 2;
			y = $urandom;
			// dividends kept below divisor times radix, no quotient overflow
			case (i % 3)
				0: ld(s, $urandom % 255 + 1);
				1: ld(s, $urandom % 65535 + 1);
				default: ld(s, y[0] ? -x : x);
			endcase
			case (i % 3)
				0: ld(d, (y & 32'hffff_0000) | ($urandom % (regs[s] << 8)));
				1: ld(d, $urandom % (regs[s] << 16));
				default: ld(d, {{16{y[15]}}, y[15:0]});
			endcase
			case (i % 3)
				0: x = regs[d][15:0] / regs[s][7:0];
				1: x = regs[d] / regs[s];
				default: x = $signed(regs[d]) / $signed(regs[s]);
			endcase
			y = regs[d] - x * regs[s];
			if (i % 3 == 0) e = {1'b0, regs[d][31:16], y[7:0], x[7:0]};
			else e = {1'b0, y[15:0], x[15:0]};
			issue(op, sz, {1'b0, d}, {sz == size_byte, s}, 1'b0, 32'h0, 1'b0, 1'b0, 8'h0);
			check("neg", condition_flags.n, (i % 3 == 0) ? x[7] : x[15]);
			check("zero", condition_flags.z, (i % 3 == 0) ? x[7:0] == 8'h0 : x[15:0] == 16'h0);
			regs[d] = e[31:0];
			chk_reg(d);
		end
		ld(3'h1, 32'h0);
		ld(3'h0, 32'h1234_5678);
		issue(unsigned_divide, size_word, 4'h0, 4'h1, 1'b0, 32'h0, 1'b0, 1'b0, 8'h0);
		check("zero", condition_flags.z, 32'h1);
		chk_reg(3'h0);
		$display("test divide done");
		results();
	end
endmodule : cpu_alu_logic_shift_bit_ops_test
